// [src/dag_pkg.sv]
package dag_pkg;

	// Data and program address widths, pointer pair count
	localparam int ADDR_W = 12;
	localparam int BYTE_W = 8;
	localparam int BANK_W = 4;
	localparam int PROG_W = 20;
	localparam int NUM_PTR = 3;

	// Common access bank split and the banks it folds onto
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] BANK_LOW = 4'h0;
	localparam logic [3:0] BANK_SFR = 4'hF;

	// Special register locations in the data map
	localparam logic [11:0] BANK_SEL_ADDR = 12'hFE0;
	localparam logic [11:0] PTR0_BASE = 12'hFE9;
	localparam logic [11:0] PTR1_BASE = 12'hFE1;
	localparam logic [11:0] PTR2_BASE = 12'hFD9;

	// Offsets of each pair's bytes and virtual operands from its base
	localparam logic [2:0] OFS_LOW = 3'h0;
	localparam logic [2:0] OFS_HIGH = 3'h1;
	localparam logic [2:0] OFS_ACC_OFFSET = 3'h2;
	localparam logic [2:0] OFS_PRE_INC = 3'h3;
	localparam logic [2:0] OFS_POST_DEC = 3'h4;
	localparam logic [2:0] OFS_POST_INC = 3'h5;
	localparam logic [2:0] OFS_INDIRECT = 3'h6;
	localparam logic [11:0] PAIR_SPAN = 12'h007;

	// Reset values, read padding and pointer step
	localparam logic [11:0] PTR_RESET = 12'h000;
	localparam logic [3:0] BANK_SEL_RESET = 4'h0;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam logic [3:0] HIGH_PAD = 4'h0;
	localparam logic [11:0] PTR_STEP = 12'h001;

	// Kind of access seen through a pointer pair
	typedef enum logic [2:0] {
		DAG_VK_LOW = 3'b000,
		DAG_VK_HIGH = 3'b001,
		DAG_VK_ACC_OFFSET = 3'b010,
		DAG_VK_PRE_INC = 3'b011,
		DAG_VK_POST_DEC = 3'b100,
		DAG_VK_POST_INC = 3'b101,
		DAG_VK_INDIRECT = 3'b110,
		DAG_VK_NONE = 3'b111
	} dag_vkind_t;

endpackage

// [src/dag_unit.sv]
`timescale 1ns/1ps
// How it works
// - Opcode low byte is the direct base address
// - Access bit one joins bank pointer and address
// - Access bit zero selects the common access bank
// - Full embedded address used, bank pointer ignored
// - Destination bit picks source register or accumulator
// - Three pointer pairs hold twelve-bit addresses
// - Virtual operands access location the pointer addresses
// - Plain indirect leaves the pointer unchanged
// - Post-decrement accesses then lowers pointer by one
// - Post-increment accesses then raises pointer by one
// - Pre-increment raises pointer then accesses location
// - Offset operand adds signed accumulator, nothing modified
// - Increments carry across the whole pointer pair
// - Pointer updates never touch arithmetic flags
// - Virtual operand through pointer reads zero
// - Write to virtual operand through pointer does nothing
// - Write landing on own pair stores, no stepping
// - Indirect reaches any bank through access operand
// - Pointer bytes are ordinary readable writable registers
// - Call and jump carry twenty-bit program address
// - Indexed literal mode only with extended set
// - Access bank splits bank zero and bank fifteen
// - Bank pointer keeps four bits, upper read zero
// - Unimplemented banks discard writes, read zero
module dag_unit #(
	parameter logic [15:0] IMPL_BANKS = 16'h800F
) (
	input wire logic clk, // Core clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic ce, // Clock enable, freezes all state when low
	input wire logic ext_set_en, // Extended instruction set enable
	input wire logic req_valid, // Operand request this cycle
	input wire logic req_full, // Operand carries a full 12-bit address
	input wire logic req_access, // Access select bit of the opcode
	input wire logic [7:0] req_faddr, // Opcode low byte address
	input wire logic [11:0] req_laddr, // Embedded full address
	input wire logic req_has_dest, // Instruction has a destination bit
	input wire logic req_dest, // Destination bit
	input wire logic req_fix_acc, // Fixed destination is the accumulator
	input wire logic req_wr, // Request writes the operand
	input wire logic [7:0] req_wdata, // Write data
	input wire logic [7:0] acc, // Accumulator value
	input wire logic lit_valid, // Call or jump literal present
	input wire logic [19:0] lit_addr, // Program address from opcode
	output logic done_r, // Request resolved, one-cycle pulse
	output logic [11:0] mem_addr_r, // Resolved data address
	output logic mem_rd_r, // Data array read strobe
	output logic mem_wr_r, // Data array write strobe
	output logic [7:0] mem_wdata_r, // Data array write data
	output logic int_rd_r, // Read data comes from rd_data_r
	output logic [7:0] rd_data_r, // Internal register or forced zero
	output logic dest_acc_r, // Result goes to the accumulator
	output logic dest_file_r, // Result goes back to the source register
	output logic flags_ok_r, // ALU status may update for this request
	output logic prog_load_r, // Program address valid, pulse
	output logic [19:0] prog_addr_r, // Program memory target
	output logic idx_avail_r, // Indexed literal offset mode available
	output logic [3:0] bank_sel_r // Bank select pointer
);

	// Code of pair_of for an address outside every pointer pair
	localparam logic [1:0] NO_PAIR = 2'd3;

	if (IMPL_BANKS[dag_pkg::BANK_SFR] == 1'b0) begin : g_chk
		$error("dag_unit: the special register bank must be implemented");
	end
	// The low half of the common access bank lands in bank zero
	if (IMPL_BANKS[dag_pkg::BANK_LOW] == 1'b0) begin : g_chk_low
		$error("dag_unit: bank zero must be implemented");
	end
	if (dag_pkg::ADDR_W != dag_pkg::BANK_W + dag_pkg::BYTE_W) begin : g_chk_width
		$error("dag_unit: address width must be bank plus byte width");
	end
	// Pair lookups serve exactly three pairs, the fourth code means none
	if (dag_pkg::NUM_PTR != int'(NO_PAIR)) begin : g_chk_pairs
		$error("dag_unit: exactly three pointer pairs are supported");
	end
	// Operand offsets are decoded from three bits
	if ($clog2(dag_pkg::PAIR_SPAN) > $bits(dag_pkg::OFS_LOW)) begin : g_chk_span
		$error("dag_unit: a pair block must fit a three-bit offset");
	end
	// Overlapping blocks would make one address hit two pairs; the decode
	// expects pair two, then the bank pointer, pair one and pair zero upwards
	if (dag_pkg::PTR0_BASE - dag_pkg::PTR1_BASE < dag_pkg::PAIR_SPAN) begin : g_chk_ov01
		$error("dag_unit: pointer pairs zero and one overlap");
	end
	if (dag_pkg::PTR1_BASE - dag_pkg::PTR2_BASE < dag_pkg::PAIR_SPAN) begin : g_chk_ov12
		$error("dag_unit: pointer pairs one and two overlap");
	end
	if (dag_pkg::BANK_SEL_ADDR - dag_pkg::PTR2_BASE < dag_pkg::PAIR_SPAN
		|| dag_pkg::BANK_SEL_ADDR >= dag_pkg::PTR1_BASE) begin : g_chk_bsel
		$error("dag_unit: the bank pointer lies inside a pointer pair");
	end
	// A block running past the top of the map would wrap onto bank zero
	if (dag_pkg::PTR0_BASE > {dag_pkg::ADDR_W{1'b1}} - dag_pkg::PAIR_SPAN) begin : g_chk_top
		$error("dag_unit: pointer pair zero runs past the top of the map");
	end
	// Virtual operands must be reachable through the common access bank
	if (dag_pkg::PTR2_BASE[dag_pkg::ADDR_W-1 -: dag_pkg::BANK_W] != dag_pkg::BANK_SFR
		|| dag_pkg::PTR2_BASE[dag_pkg::BYTE_W-1:0] < dag_pkg::ACCESS_SPLIT) begin : g_chk_sfr
		$error("dag_unit: pointer pairs must sit in the upper access bank");
	end

	// Hit test against one pointer pair's block of seven locations
	function automatic logic in_pair(input logic [11:0] a, input logic [11:0] base);
		logic [11:0] d;
		d = a - base;
		return d < dag_pkg::PAIR_SPAN;
	endfunction

	// Offset of an address inside a pair's block
	function automatic logic [2:0] pair_ofs(input logic [11:0] a, input logic [11:0] base);
		logic [11:0] d;
		d = a - base;
		return d[2:0];
	endfunction

	// Which pair an address falls in, 3 when none
	function automatic logic [1:0] pair_of(input logic [11:0] a);
		logic [1:0] p;
		p = NO_PAIR;
		if (in_pair(a, dag_pkg::PTR0_BASE)) begin
			p = 2'd0;
		end else if (in_pair(a, dag_pkg::PTR1_BASE)) begin
			p = 2'd1;
		end else if (in_pair(a, dag_pkg::PTR2_BASE)) begin
			p = 2'd2;
		end
		return p;
	endfunction

	function automatic logic [11:0] pair_base(input logic [1:0] p);
		logic [11:0] b;
		b = dag_pkg::PTR0_BASE;
		if (p == 2'd1) begin
			b = dag_pkg::PTR1_BASE;
		end else if (p == 2'd2) begin
			b = dag_pkg::PTR2_BASE;
		end
		return b;
	endfunction

	// Classify an address as a pointer byte, virtual operand or neither
	function automatic dag_pkg::dag_vkind_t vkind(input logic [11:0] a);
		logic [1:0] p;
		dag_pkg::dag_vkind_t k;
		p = pair_of(a);
		k = dag_pkg::DAG_VK_NONE;
		if (p != NO_PAIR) begin
			k = dag_pkg::dag_vkind_t'(pair_ofs(a, pair_base(p)));
		end
		return k;
	endfunction

	function automatic logic is_virtual(input dag_pkg::dag_vkind_t k);
		return k != dag_pkg::DAG_VK_NONE && k != dag_pkg::DAG_VK_LOW
			&& k != dag_pkg::DAG_VK_HIGH;
	endfunction

	logic [11:0] ptr_r [dag_pkg::NUM_PTR];
	logic [11:0] ptr_nxt [dag_pkg::NUM_PTR];
	logic [3:0] bank_sel_nxt;

	// Direct address formation
	wire logic low_half = req_faddr < dag_pkg::ACCESS_SPLIT;
	// common bank folds onto bank zero and bank fifteen
	wire logic [3:0] access_bank = low_half ? dag_pkg::BANK_LOW : dag_pkg::BANK_SFR;
	wire logic [11:0] banked_addr = {bank_sel_r, req_faddr};
	// common bank ignores the bank pointer
	wire logic [11:0] forced_addr = {access_bank, req_faddr};
	// opcode byte is the base of both direct forms
	wire logic [11:0] short_addr = req_access ? banked_addr : forced_addr;
	// embedded full address bypasses the bank pointer
	wire logic [11:0] dir_addr = req_full ? req_laddr : short_addr;

	// First level: does the operand name a virtual operand
	wire dag_pkg::dag_vkind_t kind1 = vkind(dir_addr);
	wire logic [1:0] pair1 = pair_of(dir_addr);
	// virtual operands redirect through their pointer pair
	wire logic virt1 = is_virtual(kind1);
	wire logic [1:0] psel = virt1 ? pair1 : 2'd0;
	wire logic [11:0] ptr_cur = ptr_r[psel];
	// Accumulator taken as two's complement
	wire logic [11:0] acc_sext = {{4{acc[7]}}, acc};

	// arithmetic on the whole pair carries across bytes
	// twelve-bit wrap keeps unused high bits at zero
	wire logic [11:0] ptr_inc = ptr_cur + dag_pkg::PTR_STEP;
	wire logic [11:0] ptr_dec = ptr_cur - dag_pkg::PTR_STEP;
	// signed accumulator offset, pointer and accumulator kept
	// Offset wraps within twelve bits just like the stepping
	wire logic [11:0] ptr_plus_acc = ptr_cur + acc_sext;

	logic [11:0] ind_addr;
	always_comb begin
		unique case (kind1)
			dag_pkg::DAG_VK_PRE_INC: ind_addr = ptr_inc;
			dag_pkg::DAG_VK_ACC_OFFSET: ind_addr = ptr_plus_acc;
			// plain indirect and post forms use the current value
			default: ind_addr = ptr_cur;
		endcase
	end

	// pointer address reaches any bank, bank pointer unused
	wire logic [11:0] eff_addr = virt1 ? ind_addr : dir_addr;

	// Second level: what the resolved address lands on
	wire dag_pkg::dag_vkind_t kind2 = vkind(eff_addr);
	wire logic [1:0] pair2 = pair_of(eff_addr);
	// virtual operand reached through a pointer
	wire logic nested = virt1 && is_virtual(kind2);
	wire logic hit_ptr_low = kind2 == dag_pkg::DAG_VK_LOW;
	wire logic hit_ptr_high = kind2 == dag_pkg::DAG_VK_HIGH;
	wire logic hit_ptr = hit_ptr_low || hit_ptr_high;
	wire logic hit_bank_sel = eff_addr == dag_pkg::BANK_SEL_ADDR;
	wire logic hit_int = hit_ptr || hit_bank_sel;
	// only implemented banks reach the data array
	wire logic bank_ok = IMPL_BANKS[eff_addr[11:8]];
	wire logic mem_ok = !nested && !hit_int && bank_ok;

	wire logic go = req_valid && ce;
	wire logic wr_ok = go && req_wr && !nested;
	// direct or indirect writes to pointer bytes
	wire logic wr_ptr = wr_ok && hit_ptr;
	wire logic wr_bank_sel = wr_ok && hit_bank_sel;

	// writing onto its own pair suppresses stepping
	wire logic own_pair_wr = wr_ptr && pair2 == pair1;
	wire logic step_kind = kind1 == dag_pkg::DAG_VK_PRE_INC
		|| kind1 == dag_pkg::DAG_VK_POST_INC || kind1 == dag_pkg::DAG_VK_POST_DEC;
	// Nested writes are no-operations, so they do not step the pointer either
	wire logic step = go && virt1 && step_kind && !own_pair_wr
		&& !(nested && req_wr);
	wire logic [11:0] ptr_stepped = kind1 == dag_pkg::DAG_VK_POST_DEC ? ptr_dec : ptr_inc;

	// internal register read data
	// Clamp keeps the index inside the array when no pair is hit
	wire logic [11:0] ptr_hit = ptr_r[pair2 == NO_PAIR ? 2'd0 : pair2];
	wire logic [7:0] ptr_byte = hit_ptr_low ? ptr_hit[7:0] : {dag_pkg::HIGH_PAD, ptr_hit[11:8]};
	// upper bits of the bank pointer read as zero
	wire logic [7:0] bank_byte = {dag_pkg::HIGH_PAD, bank_sel_r};
	wire logic [7:0] int_byte = hit_bank_sel ? bank_byte : ptr_byte;
	// nested reads and unimplemented reads give zero
	wire logic [7:0] rd_byte = mem_ok || !hit_int || nested ? dag_pkg::READ_ZERO : int_byte;
	// Internal registers never reach the array, its copy there stays stale
	wire logic int_rd = !mem_ok;

	// destination selection
	// Without a destination bit the instruction fixes it through req_fix_acc
	wire logic to_file = req_has_dest ? req_dest : !req_fix_acc;

	always_comb begin
		for (int i = 0; i < dag_pkg::NUM_PTR; i++) begin
			ptr_nxt[i] = ptr_r[i];
			// pair written one byte at a time, high keeps four bits
			if (wr_ptr && pair2 == 2'(i)) begin
				if (hit_ptr_low) begin
					ptr_nxt[i] = {ptr_r[i][11:8], req_wdata};
				end else begin
					ptr_nxt[i] = {req_wdata[3:0], ptr_r[i][7:0]};
				end
			end else if (step && pair1 == 2'(i)) begin
				ptr_nxt[i] = ptr_stepped;
			end
		end
	end

	// only the low four bits are stored
	assign bank_sel_nxt = wr_bank_sel ? req_wdata[3:0] : bank_sel_r;

	// Pointers and bank pointer share one enable, so a frozen core sees a stable map
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < dag_pkg::NUM_PTR; i++) begin
				ptr_r[i] <= dag_pkg::PTR_RESET;
			end
			bank_sel_r <= dag_pkg::BANK_SEL_RESET;
		end else if (ce) begin
			for (int i = 0; i < dag_pkg::NUM_PTR; i++) begin
				ptr_r[i] <= ptr_nxt[i];
			end
			bank_sel_r <= bank_sel_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			done_r <= 1'b0;
			mem_addr_r <= dag_pkg::PTR_RESET;
			mem_rd_r <= 1'b0;
			mem_wr_r <= 1'b0;
			mem_wdata_r <= dag_pkg::READ_ZERO;
		end else if (ce) begin
			// Address and data hold between requests so the core may sample late
			done_r <= req_valid;
			mem_addr_r <= req_valid ? eff_addr : mem_addr_r;
			mem_rd_r <= req_valid && mem_ok;
			// writes to unimplemented banks never strobe
			mem_wr_r <= req_valid && req_wr && mem_ok;
			mem_wdata_r <= req_valid ? req_wdata : mem_wdata_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			int_rd_r <= 1'b0;
			rd_data_r <= dag_pkg::READ_ZERO;
			dest_acc_r <= 1'b0;
			dest_file_r <= 1'b0;
			flags_ok_r <= 1'b0;
		end else if (ce) begin
			int_rd_r <= req_valid && int_rd;
			rd_data_r <= req_valid ? rd_byte : rd_data_r;
			dest_acc_r <= req_valid && !to_file;
			dest_file_r <= req_valid && to_file;
			// pointer stepping never feeds the flag update
			// flags update even when the bank is unimplemented
			flags_ok_r <= req_valid;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prog_load_r <= 1'b0;
			prog_addr_r <= {dag_pkg::PROG_W{1'b0}};
			idx_avail_r <= 1'b0;
		end else if (ce) begin
			prog_load_r <= lit_valid;
			// Program address holds between literals
			prog_addr_r <= lit_valid ? lit_addr : prog_addr_r;
			// indexed literal mode only flagged, not decoded here
			idx_avail_r <= ext_set_en;
		end
	end

endmodule

// [testbench/dag_mem.sv]
`timescale 1ns/1ps
module dag_mem (
	input wire logic clk, // Core clock
	input wire logic [11:0] addr, // Array address
	input wire logic wr, // Write strobe
	input wire logic [7:0] wdata // Write data
);
	logic [7:0] mem [0:4095];
	always @(posedge clk) begin
		if (wr === 1'b1) begin
			mem[addr] <= wdata;
		end
	end
endmodule

// [testbench/dag_unit_sva.sv]
`timescale 1ns/1ps
module dag_unit_sva (
	input wire logic clk, // Core clock
	input wire logic rst_n, // Reset, active low
	input wire logic ce, // Clock enable
	input wire logic ext_set_en, // Extended set enable
	input wire logic req_valid, // Request
	input wire logic req_full, // Full address
	input wire logic req_access, // Access bit
	input wire logic [7:0] req_faddr, // Opcode address
	input wire logic [11:0] req_laddr, // Embedded address
	input wire logic req_has_dest, // Has dest bit
	input wire logic req_dest, // Dest bit
	input wire logic req_wr, // Write
	input wire logic lit_valid, // Literal present
	input wire logic [19:0] lit_addr, // Literal
	input wire logic done_r, // Done
	input wire logic [11:0] mem_addr_r, // Address
	input wire logic mem_rd_r, // Read strobe
	input wire logic mem_wr_r, // Write strobe
	input wire logic int_rd_r, // Internal read
	input wire logic dest_acc_r, // To accumulator
	input wire logic dest_file_r, // To register
	input wire logic flags_ok_r, // Status may update
	input wire logic prog_load_r, // Program load
	input wire logic [19:0] prog_addr_r, // Program address
	input wire logic idx_avail_r, // Indexed mode available
	input wire logic [3:0] bank_sel_r // Bank pointer
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_dir;
		ce && req_valid && !req_full;
	endsequence
	sequence s_ans;
		done_r && flags_ok_r;
	endsequence
	AST_DONE: assert property (ce && req_valid |=> s_ans)
		else $error("request not answered");
	AST_DEST: assert property (s_dir ##0 req_has_dest
		|=> dest_file_r == $past(req_dest) && dest_acc_r != $past(req_dest))
		else $error("wrong destination");
	AST_BANKED: assert property (s_dir ##0 req_access && bank_sel_r < 4'h4
		|=> mem_addr_r == {$past(bank_sel_r), $past(req_faddr)})
		else $error("banked address wrong");
	AST_ACCESS_LOW: assert property (s_dir ##0 !req_access && req_faddr < 8'h60
		|=> mem_addr_r == {4'h0, $past(req_faddr)})
		else $error("access bank low address wrong");
	AST_FULL: assert property (ce && req_valid && req_full && req_laddr < 12'h400
		|=> mem_addr_r == $past(req_laddr))
		else $error("full address wrong");
	AST_UNIMPL: assert property (s_dir ##0 req_access && bank_sel_r inside {[4'h4:4'hE]}
		|=> !mem_rd_r && !mem_wr_r && int_rd_r)
		else $error("unimplemented bank reached");
	AST_BSEL: assert property (!$stable(bank_sel_r) |-> !$past(rst_n)
		|| $past(ce) && $past(req_valid) && $past(req_wr))
		else $error("bank pointer changed without write");
	AST_LIT: assert property (ce && lit_valid
		|=> prog_load_r && prog_addr_r == $past(lit_addr))
		else $error("program address wrong");
	AST_IDX: assert property (ce |=> idx_avail_r == $past(ext_set_en))
		else $error("indexed mode flag wrong");
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic ext_set_en = 1'b0;
	logic req_valid = 1'b0;
	logic req_full = 1'b0;
	logic req_access = 1'b0;
	logic [7:0] req_faddr = 8'h00;
	logic [11:0] req_laddr = 12'h000;
	logic req_has_dest = 1'b1;
	logic req_dest = 1'b0;
	logic req_fix_acc = 1'b1;
	logic req_wr = 1'b0;
	logic [7:0] req_wdata = 8'h00;
	logic [7:0] acc = 8'h00;
	logic lit_valid = 1'b0;
	logic [19:0] lit_addr = 20'h00000;
	logic done_r, mem_rd_r, mem_wr_r, int_rd_r, dest_acc_r, dest_file_r;
	logic flags_ok_r, prog_load_r, idx_avail_r;
	logic [11:0] mem_addr_r;
	logic [7:0] mem_wdata_r, rd_data_r;
	logic [19:0] prog_addr_r;
	logic [3:0] bank_sel_r;
	int fail_count = 0;
	int total_checks = 0;
	int cyc = 0;
	dag_unit i_dag_unit (.clk, .rst_n, .ce, .ext_set_en, .req_valid, .req_full, .req_access,
		.req_faddr, .req_laddr, .req_has_dest, .req_dest, .req_fix_acc, .req_wr, .req_wdata,
		.acc, .lit_valid, .lit_addr, .done_r, .mem_addr_r, .mem_rd_r, .mem_wr_r, .mem_wdata_r,
		.int_rd_r, .rd_data_r, .dest_acc_r, .dest_file_r, .flags_ok_r, .prog_load_r,
		.prog_addr_r, .idx_avail_r, .bank_sel_r);
	dag_mem i_dag_mem (.clk(clk), .addr(mem_addr_r), .wr(mem_wr_r), .wdata(mem_wdata_r));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			results();
		end
	end
	task automatic ck(input logic [11:0] g, input logic [11:0] e);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic ck_prog(input logic [19:0] g, input logic [19:0] e);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: program address %h expected %h", $time, g, e);
		end
	endtask
	// Request held one cycle; answer settled at the following falling edge
	task automatic rq(input logic a, input logic [11:0] ad, input logic w, input logic [7:0] d);
		@(negedge clk);
		req_valid = 1'b1;
		req_access = a;
		req_faddr = ad[7:0];
		req_laddr = ad;
		req_wr = w;
		req_wdata = d;
		@(negedge clk);
		req_valid = 1'b0;
		req_wr = 1'b0;
	endtask
	task automatic t_dir;
		rq(1'b0, 12'h0E0, 1'b1, 8'hF5);
		ck({8'h00, bank_sel_r}, 12'h005);
		rq(1'b1, 12'h010, 1'b1, 8'h11);
		ck({10'h000, mem_wr_r, int_rd_r}, 12'h001);
		rq(1'b0, 12'h0E0, 1'b1, 8'h02);
		req_dest = 1'b1;
		rq(1'b1, 12'h034, 1'b0, 8'h00);
		ck(mem_addr_r, 12'h234);
		ck({10'h000, dest_file_r, dest_acc_r}, 12'h002);
		req_dest = 1'b0;
		rq(1'b0, 12'h034, 1'b0, 8'h00);
		ck(mem_addr_r, 12'h034);
		ck({10'h000, dest_file_r, dest_acc_r}, 12'h001);
		rq(1'b0, 12'h080, 1'b0, 8'h00);
		ck(mem_addr_r, 12'hF80);
		req_full = 1'b1;
		rq(1'b1, 12'h3AB, 1'b0, 8'h00);
		ck(mem_addr_r, 12'h3AB);
		req_full = 1'b0;
		lit_addr = 20'hABCDE;
		lit_valid = 1'b1;
		ext_set_en = 1'b1;
		@(negedge clk);
		lit_valid = 1'b0;
		ck_prog(prog_addr_r, 20'hABCDE);
		ck({10'h000, prog_load_r, idx_avail_r}, 12'h003);
		$display("direct test done");
	endtask
	// indirect operands are named with the access bit clear
	task automatic t_ptr;
		rq(1'b0, 12'h0E9, 1'b1, 8'hFF);
		rq(1'b0, 12'h0EA, 1'b1, 8'hF1);
		rq(1'b0, 12'h0EA, 1'b0, 8'h00);
		ck({4'h0, rd_data_r}, 12'h001);
		rq(1'b0, 12'h0EE, 1'b1, 8'h5A);
		ck(mem_addr_r, 12'h1FF);
		rq(1'b0, 12'h0EA, 1'b0, 8'h00);
		ck({4'h0, rd_data_r}, 12'h002);
		ck({4'h0, i_dag_mem.mem[12'h1FF]}, 12'h05A);
		rq(1'b0, 12'h0ED, 1'b0, 8'h00);
		ck(mem_addr_r, 12'h200);
		rq(1'b0, 12'h0EA, 1'b0, 8'h00);
		ck({4'h0, rd_data_r}, 12'h001);
		rq(1'b0, 12'h0EC, 1'b0, 8'h00);
		ck(mem_addr_r, 12'h200);
		rq(1'b0, 12'h0EF, 1'b0, 8'h00);
		rq(1'b0, 12'h0EF, 1'b0, 8'h00);
		ck(mem_addr_r, 12'h200);
		acc = 8'hFE;
		rq(1'b0, 12'h0EB, 1'b0, 8'h00);
		ck(mem_addr_r, 12'h1FE);
		rq(1'b0, 12'h0E9, 1'b0, 8'h00);
		ck({4'h0, rd_data_r}, 12'h000);
		rq(1'b0, 12'h0E9, 1'b1, 8'h00);
		rq(1'b0, 12'h0EA, 1'b1, 8'h00);
		rq(1'b0, 12'h0ED, 1'b0, 8'h00);
		rq(1'b0, 12'h0EA, 1'b0, 8'h00);
		ck({4'h0, rd_data_r}, 12'h00F);
		$display("pointer test done");
	endtask
	task automatic t_nest;
		rq(1'b0, 12'h0E9, 1'b1, 8'hE7);
		rq(1'b0, 12'h0EA, 1'b1, 8'h0F);
		rq(1'b0, 12'h0EF, 1'b0, 8'h00);
		ck({3'h0, int_rd_r, rd_data_r}, 12'h100);
		rq(1'b0, 12'h0EF, 1'b1, 8'h77);
		ck({11'h000, mem_wr_r}, 12'h000);
		rq(1'b0, 12'h0E9, 1'b1, 8'hE9);
		rq(1'b0, 12'h0EE, 1'b1, 8'h42);
		rq(1'b0, 12'h0E9, 1'b0, 8'h00);
		ck({4'h0, rd_data_r}, 12'h042);
		$display("nested test done");
	endtask
	// Clock enable freeze, fixed destinations, pairs one and two
	task automatic t_mode;
		@(negedge clk);
		ce = 1'b0;
		rq(1'b0, 12'h0E0, 1'b1, 8'h09);
		ck({7'h00, done_r, bank_sel_r}, 12'h002);
		ce = 1'b1;
		req_has_dest = 1'b0;
		rq(1'b1, 12'h034, 1'b0, 8'h00);
		ck({9'h000, done_r, flags_ok_r, mem_rd_r}, 12'h007);
		ck({10'h000, dest_file_r, dest_acc_r}, 12'h001);
		req_fix_acc = 1'b0;
		rq(1'b1, 12'h034, 1'b0, 8'h00);
		ck({10'h000, dest_file_r, dest_acc_r}, 12'h002);
		req_has_dest = 1'b1;
		rq(1'b0, 12'h0D9, 1'b1, 8'h30);
		rq(1'b0, 12'h0DA, 1'b1, 8'h01);
		rq(1'b0, 12'h0DE, 1'b1, 8'hC3);
		ck(mem_addr_r, 12'h130);
		ck({3'h0, mem_wr_r, mem_wdata_r}, 12'h1C3);
		rq(1'b0, 12'h0DC, 1'b0, 8'h00);
		ck(mem_addr_r, 12'h132);
		ck({4'h0, i_dag_mem.mem[12'h130]}, 12'h0C3);
		rq(1'b0, 12'h0E1, 1'b1, 8'hF0);
		rq(1'b0, 12'h0E2, 1'b1, 8'h00);
		acc = 8'h20;
		rq(1'b0, 12'h0E3, 1'b0, 8'h00);
		ck(mem_addr_r, 12'h110);
		$display("mode test done");
	endtask
	// Mid-run reset clears pulses, pointer pair zero and the bank pointer
	task automatic t_rst;
		@(negedge clk);
		rst_n = 1'b0;
		@(negedge clk);
		rst_n = 1'b1;
		ck({7'h00, done_r, prog_load_r, idx_avail_r, int_rd_r, mem_wr_r}, 12'h000);
		rq(1'b0, 12'h0EA, 1'b0, 8'h00);
		ck({bank_sel_r, rd_data_r}, 12'h000);
		$display("reset test done");
	endtask
	initial begin
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		t_dir();
		t_ptr();
		t_nest();
		t_mode();
		t_rst();
		results();
	end
endmodule
bind dag_unit dag_unit_sva i_dag_unit_sva (.clk, .rst_n, .ce, .ext_set_en, .req_valid,
	.req_full, .req_access, .req_faddr, .req_laddr, .req_has_dest, .req_dest, .req_wr,
	.lit_valid, .lit_addr, .done_r, .mem_addr_r, .mem_rd_r, .mem_wr_r, .int_rd_r,
	.dest_acc_r, .dest_file_r, .flags_ok_r, .prog_load_r, .prog_addr_r, .idx_avail_r,
	.bank_sel_r);
